// ### rtl/stocr_pkg.sv
package stocr_pkg;
    // clock and processor cycle timing
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned CYCLE_TIME_NS  = 1000;
    localparam int unsigned CYCLE_CLKS_RAW = CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned CYCLE_CLKS     = (CYCLE_CLKS_RAW < 1) ? 1 : CYCLE_CLKS_RAW;
    localparam int unsigned STARTUP_CYCLES = 4;
    localparam int unsigned NUM_AXES       = 2;

    // register bus
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 32;
    localparam logic [7:0]  REG_CONFIG_ADDR = 8'h00;
    localparam logic [7:0]  REG_STATUS_ADDR = 8'h04;

    // config register fields
    localparam int unsigned CFG_STOP1_TRIG_BIT = 0;
    localparam int unsigned CFG_ACK_TRIG_LSB   = 1;
    localparam int unsigned CFG_SRL_TRIG_LSB   = 3;
    localparam int unsigned CFG_TO_USED_BIT    = 5;
    localparam int unsigned CFG_RL_USED_BIT    = 6;
    localparam int unsigned CFG_SAFE_RUN_BIT   = 7;
    localparam int unsigned CFG_W              = 8;
    localparam logic [7:0]  CFG_RESET          = 8'h20;

    // status register fields
    localparam int unsigned ST_STATE_LSB    = 0;
    localparam int unsigned ST_FAULT_BIT    = 2;
    localparam int unsigned ST_FEEDBACK_BIT = 3;
    localparam int unsigned ST_ENABLE_BIT   = 4;
    localparam int unsigned ST_AXIS_LSB     = 8;

    typedef enum logic [1:0] {
        ST_TORQUE_OFF = 2'b00,
        ST_STARTUP    = 2'b01,
        ST_RUN        = 2'b10,
        ST_SAFE_RUN   = 2'b11
    } stocr_state_type;

    typedef enum logic [1:0] {
        TRIG_NOP     = 2'b00,
        TRIG_ACK_ERR = 2'b01,
        TRIG_RESTART = 2'b10
    } stocr_trig_type;

    localparam logic STOP1_TRIG_RESTART = 1'b1;
endpackage

// ### rtl/stocr_reset_ctrl.sv
`timescale 1ns/100ps
module stocr_reset_ctrl #(
    parameter int unsigned NUM_AXES       = stocr_pkg::NUM_AXES,
    parameter int unsigned CYCLE_CLKS     = stocr_pkg::CYCLE_CLKS,
    parameter int unsigned STARTUP_CYCLES = stocr_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    // register port
    input  wire logic [stocr_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [stocr_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [stocr_pkg::DATA_W-1:0] reg_rdata_out,
    // safety controller and drive controller
    input  wire logic                         stop1_activate_input_in,
    input  wire logic                         torque_off_activate_input_in,
    input  wire logic                         restart_lock_function_in,
    input  wire logic                         ack_cmd_in,
    input  wire logic                         fault_event_in,
    input  wire logic                         motion_monitor_active_in,
    input  wire logic [NUM_AXES-1:0]          axis_limit_violation_in,
    // drive side
    output logic                              torque_off_feedback_out,
    output logic                              output_stage_enable_out,
    output logic                              pulse_block_out,
    output logic      [1:0]                   op_state_out
);
    import stocr_pkg::*;

    localparam int unsigned TICK_W = (CYCLE_CLKS < 2) ? 1 : $clog2(CYCLE_CLKS);
    localparam int unsigned SU_W   = (STARTUP_CYCLES < 2) ? 1 : $clog2(STARTUP_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLE_CLKS - 1);
    localparam logic [SU_W-1:0]   SU_LAST   = SU_W'(STARTUP_CYCLES);

    stocr_state_type     state_q, state_d;
    logic [TICK_W-1:0]   tick_cnt_q;
    logic                tick;
    logic [SU_W-1:0]     su_cnt_q;
    logic [CFG_W-1:0]    cfg_q;
    logic                fault_q;
    logic [NUM_AXES-1:0] axis_fault_q;
    logic                stop1_prev_q, to_prev_q, srl_prev_q;
    logic [DATA_W-1:0]   rdata_q;

    // processor cycle enable; one pulse every CYCLE_CLKS clocks
    assign tick = (tick_cnt_q == TICK_LAST);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
        end
    end

    // configuration fields, one copy for the whole device
    wire             cfg_stop1_restart = (cfg_q[CFG_STOP1_TRIG_BIT] == STOP1_TRIG_RESTART);
    wire [1:0]       cfg_ack_trig      = cfg_q[CFG_ACK_TRIG_LSB +: 2];
    wire [1:0]       cfg_srl_trig      = cfg_q[CFG_SRL_TRIG_LSB +: 2];
    wire             cfg_to_used       = cfg_q[CFG_TO_USED_BIT];
    wire             cfg_rl_used       = cfg_q[CFG_RL_USED_BIT];
    wire             cfg_safe_run      = cfg_q[CFG_SAFE_RUN_BIT];

    // edge detection on the safety reset inputs
    // rising edges only
    wire stop1_rise = stop1_activate_input_in & ~stop1_prev_q;
    wire to_rise    = torque_off_activate_input_in & ~to_prev_q & cfg_to_used;
    wire srl_rise   = restart_lock_function_in & ~srl_prev_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stop1_prev_q <= 1'b1;   // a level present at reset is not an edge
            to_prev_q    <= 1'b1;
            srl_prev_q   <= 1'b1;
        end else begin
            stop1_prev_q <= stop1_activate_input_in;
            to_prev_q    <= torque_off_activate_input_in;
            srl_prev_q   <= restart_lock_function_in;
        end
    end

    // trigger decode; codes not listed behave as no operation
    // stop-1 edge trigger
    wire s1_trig   = (stop1_rise | to_rise) & cfg_stop1_restart;
    wire ack_ack   = ack_cmd_in & ((cfg_ack_trig == TRIG_ACK_ERR) | (cfg_ack_trig == TRIG_RESTART));
    wire ack_rst   = ack_cmd_in & (cfg_ack_trig == TRIG_RESTART);
    wire srl_ack   = srl_rise & ((cfg_srl_trig == TRIG_ACK_ERR) | (cfg_srl_trig == TRIG_RESTART));
    wire srl_rst   = srl_rise & (cfg_srl_trig == TRIG_RESTART);
    // acknowledge happens regardless of the restart gate
    wire ack_now   = s1_trig | ack_ack | srl_ack;
    wire rst_req   = s1_trig | ack_rst | srl_rst;

    // restart permission from input levels
    // stop-1 high, torque-off and restart lock high when used
    wire permit    = stop1_activate_input_in
                   & (~cfg_to_used | torque_off_activate_input_in)
                   & (~cfg_rl_used | restart_lock_function_in);

    // limit violations, sampled once per processor cycle
    // cycle-rate sampling
    wire [NUM_AXES-1:0] viol_now = (tick & motion_monitor_active_in) ?
                                   axis_limit_violation_in : '0;
    wire new_fault  = fault_event_in | (|viol_now);
    wire stop_level = ~stop1_activate_input_in | (cfg_to_used & ~torque_off_activate_input_in);
    wire in_sto     = (state_q == ST_TORQUE_OFF);
    // only a device in torque-off can restart
    wire restart_go = in_sto & rst_req & permit & ~new_fault;
    wire su_done    = (su_cnt_q == SU_LAST);

    // operating state transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_TORQUE_OFF: begin
                if (restart_go) begin
                    state_d = ST_STARTUP;
                end
            end
            // startup then run or safe run
            ST_STARTUP: begin
                if (new_fault | stop_level) begin
                    state_d = ST_TORQUE_OFF;
                end else if (su_done) begin
                    state_d = cfg_safe_run ? ST_SAFE_RUN : ST_RUN;
                end
            end
            ST_RUN, ST_SAFE_RUN: begin
                if (new_fault | stop_level) begin
                    state_d = ST_TORQUE_OFF;
                end
            end
            default: begin
                state_d = ST_TORQUE_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_TORQUE_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // startup length in processor cycles
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            su_cnt_q <= '0;
        end else if (state_q != ST_STARTUP) begin
            su_cnt_q <= '0;
        end else if (tick && !su_done) begin
            su_cnt_q <= su_cnt_q + SU_W'(1);
        end
    end

    // stored faults; a new fault in the acknowledge cycle survives
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fault_q      <= 1'b0;
            axis_fault_q <= '0;
        end else begin
            fault_q      <= new_fault | (fault_q & ~ack_now);
            axis_fault_q <= viol_now | (axis_fault_q & ~{NUM_AXES{ack_now}});
        end
    end

    // drive outputs decoded from the state register
    // output stage blocked in torque-off and startup
    assign output_stage_enable_out = (state_q == ST_RUN) | (state_q == ST_SAFE_RUN);
    assign pulse_block_out         = ~output_stage_enable_out;
    assign torque_off_feedback_out = in_sto;
    assign op_state_out            = state_q;

    // register port decode
    wire cfg_sel  = (reg_addr_in == REG_CONFIG_ADDR);
    wire stat_sel = (reg_addr_in == REG_STATUS_ADDR);
    wire [DATA_W-1:0] status_word = {{(DATA_W-ST_AXIS_LSB-NUM_AXES){1'b0}}, axis_fault_q,
                                     3'b000, output_stage_enable_out,
                                     torque_off_feedback_out, fault_q, state_q};
    wire [DATA_W-1:0] rd_mux = cfg_sel  ? {{(DATA_W-CFG_W){1'b0}}, cfg_q} :
                               stat_sel ? status_word : '0;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_q <= CFG_RESET;
        end else if (reg_wr_in && cfg_sel) begin
            cfg_q <= reg_wdata_in[CFG_W-1:0];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : '0;
        end
    end
    assign reg_rdata_out = rdata_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_restart;
        in_sto && restart_go ##1 state_q == ST_STARTUP;
    endsequence
    sequence s_reach_run;
        ##[1:200] (state_q == ST_RUN || state_q == ST_SAFE_RUN || in_sto);
    endsequence

    property p_violation_shutdown;
        (|viol_now) |=> in_sto && !output_stage_enable_out;
    endproperty
    a_violation_shutdown: assert property (p_violation_shutdown)
        else $error("violation did not shut the axis down");

    property p_sampled_on_tick;
        (fault_q && !$past(fault_q) && !$past(fault_event_in)) |-> $past(tick);
    endproperty
    a_sampled_on_tick: assert property (p_sampled_on_tick)
        else $error("violation latched outside a processor cycle tick");

    property p_enable_blocked;
        in_sto |-> !output_stage_enable_out && pulse_block_out;
    endproperty
    a_enable_blocked: assert property (p_enable_blocked)
        else $error("output stage enabled in torque-off");

    property p_feedback;
        torque_off_feedback_out == (op_state_out == ST_TORQUE_OFF);
    endproperty
    a_feedback: assert property (p_feedback)
        else $error("feedback does not follow torque-off state");

    property p_hold_sto;
        in_sto && !rst_req |=> in_sto;
    endproperty
    a_hold_sto: assert property (p_hold_sto)
        else $error("torque-off left without reset");

    property p_restart_order;
        s_restart |-> s_reach_run;
    endproperty
    a_restart_order: assert property (p_restart_order)
        else $error("startup did not end in time");

    // judged on the state register, not on the permit term that builds it
    property p_restart_levels;
        (in_sto ##1 state_q == ST_STARTUP) |->
            $past(stop1_activate_input_in && (!cfg_to_used || torque_off_activate_input_in));
    endproperty
    a_restart_levels: assert property (p_restart_levels)
        else $error("restart without activation inputs high");

    property p_edge_only;
        s1_trig |-> $rose(stop1_activate_input_in) || $rose(torque_off_activate_input_in);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("stop trigger without rising edge");

    property p_lock_gate;
        (in_sto ##1 state_q == ST_STARTUP) |-> $past(!cfg_rl_used || restart_lock_function_in);
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("restart while restart lock low");

    property p_ack_clears;
        ack_now && !new_fault |=> !fault_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("acknowledge did not clear stored faults");

    property p_no_effect_outside;
        !in_sto && !new_fault && !stop_level && rst_req && state_q != ST_STARTUP
            |=> $stable(state_q);
    endproperty
    a_no_effect_outside: assert property (p_no_effect_outside)
        else $error("trigger changed state outside torque-off");
endmodule

// ### verification/stocr_ctl_model.sv
`timescale 1ns/100ps
module stocr_ctl_model (
    // clock
    input  wire logic clk_in,
    // lines into the safety module
    output logic      stop1_out,
    output logic      torque_off_out,
    output logic      lock_out,
    output logic      ack_out
);
    // stop lines idle at 1 (no stop asked); the module sees no edge at release
    initial begin
        stop1_out = 1'b1;
        torque_off_out = 1'b1;
        lock_out = 1'b1;
        ack_out = 1'b0;
    end

    // a 0 then 1 sequence here is what makes the edge
    task automatic set_lines(input logic s1, input logic to, input logic lk);
        @(posedge clk_in);
        stop1_out <= s1;
        torque_off_out <= to;
        lock_out <= lk;
    endtask

    // the acknowledge command is a single-cycle pulse, so one call is one command
    task automatic pulse_ack();
        @(posedge clk_in);
        ack_out <= 1'b1;
        @(posedge clk_in);
        ack_out <= 1'b0;
    endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
    import stocr_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        fault_in = 1'b0;
    logic        mon_in = 1'b0;
    logic [1:0]  viol_in = 2'h0;
    logic [31:0] rdata;
    logic        fb;
    logic        en;
    logic        pb;
    logic [1:0]  st;
    wire         s1;
    wire         to;
    wire         lk;
    wire         ack;
    int          n_fail = 0;
    int          compares = 0;

    always #25 clk_in = ~clk_in;

    stocr_ctl_model m (.clk_in(clk_in), .stop1_out(s1), .torque_off_out(to),
        .lock_out(lk), .ack_out(ack));

    // short processor cycle and startup keep the run brief
    stocr_reset_ctrl #(.NUM_AXES(2), .CYCLE_CLKS(2), .STARTUP_CYCLES(2)) dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .stop1_activate_input_in(s1),
        .torque_off_activate_input_in(to), .restart_lock_function_in(lk),
        .ack_cmd_in(ack), .fault_event_in(fault_in), .motion_monitor_active_in(mon_in),
        .axis_limit_violation_in(viol_in), .torque_off_feedback_out(fb),
        .output_stage_enable_out(en), .pulse_block_out(pb), .op_state_out(st));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask

    task automatic wait_state(input logic [1:0] exp, input int lim);
        for (int i = 0; i < lim && st !== exp; i++) @(negedge clk_in);
        chk("op_state", {30'h0, st}, {30'h0, exp});
    endtask

    task automatic hold(input int n, input logic [1:0] exp);
        repeat (n) @(negedge clk_in);
        chk("op_state held", {30'h0, st}, {30'h0, exp});
    endtask

    task automatic fault_pulse();
        @(posedge clk_in);
        fault_in <= 1'b1;
        @(posedge clk_in);
        fault_in <= 1'b0;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        chk("feedback", {31'h0, fb}, 32'h0000_0001);
        chk("enable", {31'h0, en}, 32'h0000_0000);
        chk("pulse block", {31'h0, pb}, 32'h0000_0001);
        rd(8'h00, d);
        chk("config reset", d, 32'h0000_0020);
        rd(8'h08, d);
        chk("unmapped read", d, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_stop1();
        wr(8'h00, 32'h0000_0020);
        m.set_lines(1'b0, 1'b1, 1'b1);
        m.set_lines(1'b1, 1'b1, 1'b1);
        hold(6, ST_TORQUE_OFF);
        wr(8'h00, 32'h0000_0021);
        hold(6, ST_TORQUE_OFF);
        m.set_lines(1'b0, 1'b0, 1'b1);
        m.set_lines(1'b1, 1'b0, 1'b1);
        hold(6, ST_TORQUE_OFF);
        m.set_lines(1'b1, 1'b1, 1'b1);
        wait_state(ST_STARTUP, 4);
        wait_state(ST_RUN, 40);
        chk("feedback run", {31'h0, fb}, 32'h0000_0000);
        chk("enable run", {31'h0, en}, 32'h0000_0001);
        $display("test stop1 done");
    endtask

    // every trigger code for the acknowledge command or the restart lock
    task automatic t_codes(input logic use_lock);
        logic [31:0] d;
        logic [1:0]  code;
        for (int k = 0; k < 4; k++) begin
            code = (k == 3) ? 2'd2 : ((k == 2) ? 2'd3 : 2'(k));
            wr(8'h00, 32'h0000_0020 | (32'(code) << (use_lock ? 3 : 1)));
            fault_pulse();
            wait_state(ST_TORQUE_OFF, 4);
            if (use_lock) begin
                m.set_lines(1'b1, 1'b1, 1'b0);
                m.set_lines(1'b1, 1'b1, 1'b1);
            end else begin
                m.pulse_ack();
            end
            if (code == 2'd2) begin
                wait_state(ST_STARTUP, 4);
            end else begin
                hold(4, ST_TORQUE_OFF);
            end
            // codes 1 and 2 acknowledge, so the fault stays only for 0 and 3
            rd(8'h04, d);
            chk("fault stored", {31'h0, d[2]}, {31'h0, (code == 2'd0 || code == 2'd3)});
        end
        wait_state(ST_RUN, 40);
        // the same restart trigger again, now outside torque-off
        if (use_lock) begin
            m.set_lines(1'b1, 1'b1, 1'b0);
            m.set_lines(1'b1, 1'b1, 1'b1);
        end else begin
            m.pulse_ack();
        end
        hold(4, ST_RUN);
        $display("test trigger codes done");
    endtask

    task automatic t_lock_gate();
        logic [31:0] d;
        wr(8'h00, 32'h0000_0064);
        m.set_lines(1'b1, 1'b1, 1'b0);
        fault_pulse();
        m.pulse_ack();
        hold(6, ST_TORQUE_OFF);
        rd(8'h04, d);
        chk("gated ack fault", {31'h0, d[2]}, 32'h0000_0000);
        m.set_lines(1'b1, 1'b1, 1'b1);
        m.pulse_ack();
        wait_state(ST_STARTUP, 4);
        $display("test lock gate done");
    endtask

    task automatic t_safe_run();
        logic [31:0] d;
        // torque-off input left unused: its low level neither blocks restart nor stops
        wr(8'h00, 32'h0000_0081);
        m.set_lines(1'b0, 1'b0, 1'b1);
        m.set_lines(1'b1, 1'b0, 1'b1);
        wait_state(ST_SAFE_RUN, 40);
        hold(4, ST_SAFE_RUN);
        // a violation counts only while motion monitoring is active
        @(posedge clk_in);
        viol_in <= 2'h2;
        hold(6, ST_SAFE_RUN);
        @(posedge clk_in);
        mon_in <= 1'b1;
        // one processor cycle of two clocks plus the state edge
        wait_state(ST_TORQUE_OFF, 4);
        chk("pulse block", {31'h0, pb}, 32'h0000_0001);
        rd(8'h04, d);
        chk("axis latched", {30'h0, d[9:8]}, 32'h0000_0002);
        @(posedge clk_in);
        viol_in <= 2'h0;
        mon_in <= 1'b0;
        m.set_lines(1'b1, 1'b1, 1'b1);
        $display("test safe run done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_stop1();
        t_codes(1'b0);
        t_codes(1'b1);
        t_lock_gate();
        t_safe_run();
        print_verdict();
    end

    // whole run is well under a thousand cycles; this only cuts a hang
    initial begin
        #(50 * 20000);
        n_fail++;
        print_verdict();
    end
endmodule
